/* File: rtl/ppt_port.sv */
// parallel port register file, shared fifo and automatic handshakes
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module ppt_port
	import ppt_pkg::*;
#(
	parameter int DEPTH  = FIFO_DEPTH,
	parameter int THRESH = SVC_THRESH
) (
	input  wire logic        MCLK_I,
	input  wire logic        RST_B_I,
	input  wire logic [1:0]  BASE_SEL_I,
	input  wire logic        EPP_OPTION_I,
	input  wire logic [15:0] IO_ADDR_I,
	input  wire logic        IO_WR_I,
	input  wire logic        IO_RD_I,
	input  wire logic [7:0]  IO_WDATA_I,
	output var  logic [7:0]  IO_RDATA_O,
	output var  logic        IO_RVALID_O,
	output var  logic        DMA_REQ_O,
	input  wire logic        DMA_ACK_I,
	input  wire logic        DMA_TC_I,
	output var  logic        IRQ_O,
	input  wire logic [7:0]  PD_I,
	output var  logic [7:0]  PD_O,
	output var  logic        PD_OE_O,
	output var  logic        STROBE_B_O,
	output var  logic        AUTOFD_B_O,
	output var  logic        INIT_B_O,
	output var  logic        SELIN_B_O,
	input  wire logic        BUSY_I,
	input  wire logic        ACK_B_I,
	input  wire logic        PERROR_I,
	input  wire logic        SELECT_I,
	input  wire logic        FAULT_B_I
);
	localparam int CW = $clog2(DEPTH) + 1;
	localparam int TW = $clog2(STROBE_CYC + 1);
	localparam logic [CW-1:0] THR = CW'(THRESH);
	localparam logic [CW-1:0] DEP = CW'(DEPTH);
	localparam logic [TW-1:0] STB_CNT = TW'(STROBE_CYC);

	generate
		if (THRESH < 1 || THRESH > DEPTH || DEPTH != FIFO_DEPTH) begin : g_chk
			$error("fifo depth must be 16 and threshold within it");
		end
	endgenerate

	typedef enum logic [2:0] {
		HS_IDLE,
		HS_SETUP,
		HS_STROBE,
		HS_BUSY_LO,
		HS_ACK_HI
	} hs_state_t;

	// ------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------
	port_mode_t mode_ff;
	logic       fault_dis_ff;
	logic       dma_en_ff;
	logic       service_ff;
	logic [5:0] ctl_ff;
	logic [7:0] data_ff;
	logic       ack_q_ff;
	logic       fault_q_ff;
	hs_state_t  hs_ff;
	logic [TW-1:0] tmr_ff;
	logic [7:0] hs_byte_ff;
	logic       hs_cmd_ff;
	logic       hs_strobe_ff;
	logic       hs_hack_ff;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic [15:0] base;
	logic        base_ok;
	logic        port_on;
	logic        fwd;
	logic        auto_mode;
	logic        fifo_mode;

	function automatic logic hit(input logic [15:0] addr,
	                             input logic [15:0] b,
	                             input logic [15:0] off);
		hit = (addr == b + off);
	endfunction : hit

	function automatic logic legal_mode(input port_mode_t cur,
	                                    input port_mode_t nxt);
		legal_mode = (cur == MODE_SPP) || (cur == MODE_PS2) ||
		             (nxt == MODE_SPP) || (nxt == MODE_PS2);
	endfunction : legal_mode

	always_comb begin
		unique case (BASE_SEL_I)
			SEL_378: base = BASE_378;
			SEL_278: base = BASE_278;
			SEL_3BC: base = BASE_3BC;
			default: base = BASE_378;
		endcase
	end
	assign base_ok = (BASE_SEL_I != 2'h3);
	// the extra EPP decode does not fit next to the 3BC slot
	assign port_on = base_ok && !(BASE_SEL_I == SEL_3BC &&
	                 mode_ff == MODE_EPP && EPP_OPTION_I);
	// direction is ignored in 000 and 010
	assign fwd = !ctl_ff[CTL_DIR] || mode_ff == MODE_SPP ||
	             mode_ff == MODE_CMP;
	assign auto_mode = (mode_ff == MODE_CMP) || (mode_ff == MODE_ECP);
	assign fifo_mode = auto_mode || (mode_ff == MODE_TEST);

	logic wr_data;
	logic wr_ctl;
	logic wr_fifo;
	logic wr_ecr;
	logic rd_fifo;
	logic rd_hit_fifo;

	assign wr_data = IO_WR_I && port_on && hit(IO_ADDR_I, base, OFF_DATA);
	assign wr_ctl  = IO_WR_I && port_on && hit(IO_ADDR_I, base, OFF_CTRL);
	assign wr_fifo = IO_WR_I && port_on && hit(IO_ADDR_I, base, OFF_FIFO);
	assign wr_ecr  = IO_WR_I && port_on && hit(IO_ADDR_I, base, OFF_ECR);
	assign rd_hit_fifo = IO_RD_I && port_on &&
	                     hit(IO_ADDR_I, base, OFF_FIFO);

	// ------------------------------------------------------------
	// shared fifo
	// ------------------------------------------------------------
	fifo_word_t      push_word;
	logic            push_req;
	logic            fifo_in_ready;
	fifo_word_t      head;
	logic            fifo_out_valid;
	logic            pop_req;
	logic [CW-1:0]   fifo_count;
	logic            hs_push;
	logic            hs_pop;
	logic            host_push;
	logic            dma_wr;
	logic            dma_rd;

	assign dma_wr = DMA_ACK_I && dma_en_ff && fifo_mode && fwd;
	assign dma_rd = DMA_ACK_I && dma_en_ff && fifo_mode && !fwd;
	// address view takes the data slot only in ECP forward
	assign host_push = (wr_fifo && (mode_ff == MODE_CMP ||
	                   mode_ff == MODE_TEST ||
	                   (mode_ff == MODE_ECP && fwd))) ||
	                   (wr_data && mode_ff == MODE_ECP && fwd);
	assign rd_fifo = rd_hit_fifo && (mode_ff == MODE_TEST ||
	                 (mode_ff == MODE_ECP && !fwd));

	always_comb begin
		push_word = '0;
		if (hs_push) begin
			push_word.cmd    = !BUSY_I;
			push_word.byte_v = PD_I;
		end else begin
			push_word.cmd    = wr_data;
			push_word.byte_v = IO_WDATA_I;
		end
	end
	assign push_req = hs_push || host_push || dma_wr;
	assign pop_req  = hs_pop || rd_fifo || dma_rd;

	ppt_fifo #(
		.WIDTH ($bits(fifo_word_t)),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_i       (MCLK_I),
		.rst_b_i     (RST_B_I),
		.flush_i     (mode_ff == MODE_SPP),
		.in_data_i   (push_word),
		.in_valid_i  (push_req),
		.in_ready_o  (fifo_in_ready),
		.out_data_o  (head),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (pop_req),
		.count_o     (fifo_count)
	);

	// ------------------------------------------------------------
	// automatic handshake
	// ------------------------------------------------------------
	// forward sends wait for the fifo; reverse stalls while it is full
	assign hs_pop  = hs_ff == HS_IDLE && fwd && auto_mode &&
	                 fifo_out_valid && !BUSY_I;
	assign hs_push = hs_ff == HS_IDLE && !fwd &&
	                 mode_ff == MODE_ECP && !ACK_B_I && fifo_in_ready;

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I || !auto_mode || !port_on) begin
			hs_ff        <= HS_IDLE;
			tmr_ff       <= '0;
			hs_strobe_ff <= 1'b0;
			hs_hack_ff   <= 1'b0;
			hs_byte_ff   <= BYTE_ZERO;
			hs_cmd_ff    <= 1'b0;
		end else begin
			unique case (hs_ff)
				HS_IDLE: begin
					if (hs_pop) begin
						hs_byte_ff <= head.byte_v;
						hs_cmd_ff  <= head.cmd;
						hs_hack_ff <= head.cmd;
						tmr_ff     <= STB_CNT;
						hs_ff      <= HS_SETUP;
					end else if (hs_push) begin
						hs_hack_ff <= 1'b1;
						hs_ff      <= HS_ACK_HI;
					end
				end
				HS_SETUP: begin
					tmr_ff <= tmr_ff - 1'b1;
					if (tmr_ff == TW'(1)) begin
						hs_strobe_ff <= 1'b1;
						tmr_ff       <= STB_CNT;
						hs_ff        <= HS_STROBE;
					end
				end
				HS_STROBE: begin
					if (tmr_ff != '0) begin
						tmr_ff <= tmr_ff - 1'b1;
					end
					// compat times the pulse, ECP waits for busy
					if ((mode_ff == MODE_CMP && tmr_ff == TW'(1)) ||
					    (mode_ff == MODE_ECP && BUSY_I)) begin
						hs_strobe_ff <= 1'b0;
						hs_ff        <= HS_BUSY_LO;
					end
				end
				HS_BUSY_LO: begin
					if (!BUSY_I) begin
						hs_ff <= HS_IDLE;
					end
				end
				HS_ACK_HI: begin
					if (ACK_B_I) begin
						hs_hack_ff <= 1'b0;
						hs_ff      <= HS_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// control, extended control and data latch
	// ------------------------------------------------------------
	port_mode_t new_mode;
	logic       fault_evt;
	logic       ack_evt;
	logic       svc_cond;
	logic       svc_evt;

	assign new_mode = port_mode_t'(IO_WDATA_I[7:ECR_MODE_LO]);

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			mode_ff <= MODE_SPP;
		end else if (wr_ecr && legal_mode(mode_ff, new_mode)) begin
			mode_ff <= new_mode;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			fault_dis_ff <= 1'b1;
			dma_en_ff    <= 1'b0;
		end else if (wr_ecr) begin
			fault_dis_ff <= IO_WDATA_I[ECR_FAULT_DIS];
			dma_en_ff    <= IO_WDATA_I[ECR_DMA_EN];
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			service_ff <= 1'b1;
		end else if (svc_evt) begin
			service_ff <= 1'b1;
		end else if (wr_ecr) begin
			service_ff <= IO_WDATA_I[ECR_SERVICE];
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			ctl_ff <= CTL_RESET;
		end else if (wr_ctl) begin
			ctl_ff[CTL_ACK_IE:0] <= IO_WDATA_I[CTL_ACK_IE:0];
			if (mode_ff == MODE_PS2) begin
				ctl_ff[CTL_DIR] <= IO_WDATA_I[CTL_DIR];
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			data_ff <= BYTE_ZERO;
		end else if (wr_data && mode_ff != MODE_ECP) begin
			data_ff <= IO_WDATA_I;
		end
	end

	// ------------------------------------------------------------
	// events and interrupt
	// ------------------------------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			ack_q_ff   <= 1'b1;
			fault_q_ff <= 1'b1;
		end else begin
			ack_q_ff   <= ACK_B_I;
			fault_q_ff <= FAULT_B_I;
		end
	end

	assign ack_evt = ctl_ff[CTL_ACK_IE] && ACK_B_I && !ack_q_ff;
	assign fault_evt = mode_ff == MODE_ECP && port_on &&
	                   ((!fault_dis_ff && fault_q_ff && !FAULT_B_I) ||
	                    (wr_ecr && fault_dis_ff &&
	                     !IO_WDATA_I[ECR_FAULT_DIS] && !FAULT_B_I));
	// thresholds fixed: no register holds them
	always_comb begin
		if (dma_en_ff) begin
			svc_cond = DMA_ACK_I && DMA_TC_I;
		end else if (fwd) begin
			svc_cond = (DEP - fifo_count) >= THR;
		end else begin
			svc_cond = fifo_count >= THR;
		end
	end
	assign svc_evt = !service_ff && fifo_mode && port_on && svc_cond;

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			IRQ_O <= 1'b0;
		end else begin
			IRQ_O <= ack_evt || fault_evt || svc_evt;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			DMA_REQ_O <= 1'b0;
		end else begin
			DMA_REQ_O <= dma_en_ff && !service_ff && fifo_mode &&
			             port_on && (fwd ? fifo_in_ready : fifo_out_valid);
		end
	end

	// ------------------------------------------------------------
	// register read-back
	// ------------------------------------------------------------
	logic [7:0] rd_val;
	logic       rd_map;

	// unmapped offsets give no answer at all
	always_comb begin
		rd_val = BYTE_ZERO;
		rd_map = 1'b1;
		if (hit(IO_ADDR_I, base, OFF_DATA)) begin
			rd_val = (mode_ff == MODE_PS2) ? PD_I : data_ff;
		end else if (hit(IO_ADDR_I, base, OFF_STATUS)) begin
			rd_val = {!BUSY_I, ACK_B_I, PERROR_I, SELECT_I,
			          FAULT_B_I, STAT_ONES};
		end else if (hit(IO_ADDR_I, base, OFF_CTRL)) begin
			rd_val = {CTL_ONES, ctl_ff};
		end else if (hit(IO_ADDR_I, base, OFF_FIFO)) begin
			rd_val = (mode_ff == MODE_CFG) ? CFGA_VALUE :
			         head.byte_v;
		end else if (hit(IO_ADDR_I, base, OFF_CFGB)) begin
			rd_val = (mode_ff == MODE_CFG) ?
			         {1'b0, IRQ_O, CFGB_ONES} : BYTE_ZERO;
		end else if (hit(IO_ADDR_I, base, OFF_ECR)) begin
			rd_val = {mode_ff, fault_dis_ff, dma_en_ff, service_ff,
			          !fifo_in_ready, !fifo_out_valid};
		end else begin
			rd_map = 1'b0;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			IO_RDATA_O  <= BYTE_ZERO;
			IO_RVALID_O <= 1'b0;
		end else begin
			IO_RVALID_O <= (IO_RD_I && port_on && rd_map) || dma_rd;
			if (dma_rd) begin
				IO_RDATA_O <= head.byte_v;
			end else if (IO_RD_I && port_on && rd_map) begin
				IO_RDATA_O <= rd_val;
			end
		end
	end

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			PD_O       <= BYTE_ZERO;
			PD_OE_O    <= 1'b0;
			STROBE_B_O <= 1'b1;
			AUTOFD_B_O <= 1'b1;
			INIT_B_O   <= 1'b0;
			SELIN_B_O  <= 1'b1;
		end else begin
			PD_O       <= (auto_mode && fwd) ? hs_byte_ff : data_ff;
			PD_OE_O    <= port_on && fwd;
			INIT_B_O   <= ctl_ff[CTL_INIT];
			SELIN_B_O  <= !ctl_ff[CTL_SELIN];
			if (auto_mode) begin
				STROBE_B_O <= !hs_strobe_ff;
				AUTOFD_B_O <= fwd ? !hs_cmd_ff : hs_hack_ff;
			end else begin
				STROBE_B_O <= !ctl_ff[CTL_STROBE];
				AUTOFD_B_O <= !ctl_ff[CTL_AUTOFD];
			end
		end
	end
endmodule : ppt_port
`default_nettype wire

/* File: rtl/ppt_pkg.sv */
// constants, modes and carrier types of the parallel port block
package ppt_pkg;
	// ------------------------------------------------------------
	// base addresses and register offsets from base
	// ------------------------------------------------------------
	localparam logic [15:0] BASE_378   = 16'h0378;
	localparam logic [15:0] BASE_278   = 16'h0278;
	localparam logic [15:0] BASE_3BC   = 16'h03BC;
	localparam logic [1:0]  SEL_378    = 2'h0;
	localparam logic [1:0]  SEL_278    = 2'h1;
	localparam logic [1:0]  SEL_3BC    = 2'h2;
	localparam logic [15:0] OFF_DATA   = 16'h0000;
	localparam logic [15:0] OFF_STATUS = 16'h0001;
	localparam logic [15:0] OFF_CTRL   = 16'h0002;
	localparam logic [15:0] OFF_FIFO   = 16'h0400;
	localparam logic [15:0] OFF_CFGB   = 16'h0401;
	localparam logic [15:0] OFF_ECR    = 16'h0402;
	// ------------------------------------------------------------
	// modes and field positions
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_SPP  = 3'h0,
		MODE_PS2  = 3'h1,
		MODE_CMP  = 3'h2,
		MODE_ECP  = 3'h3,
		MODE_EPP  = 3'h4,
		MODE_RSVD = 3'h5,
		MODE_TEST = 3'h6,
		MODE_CFG  = 3'h7
	} port_mode_t;
	localparam int ECR_MODE_LO   = 5;
	localparam int ECR_FAULT_DIS = 4;
	localparam int ECR_DMA_EN    = 3;
	localparam int ECR_SERVICE   = 2;
	localparam int ECR_FULL      = 1;
	localparam int ECR_EMPTY     = 0;
	localparam int CTL_DIR       = 5;
	localparam int CTL_ACK_IE    = 4;
	localparam int CTL_SELIN     = 3;
	localparam int CTL_INIT      = 2;
	localparam int CTL_AUTOFD    = 1;
	localparam int CTL_STROBE    = 0;
	localparam logic [5:0] CTL_RESET  = 6'h00;
	localparam logic [1:0] CTL_ONES   = 2'h3;
	localparam logic [2:0] STAT_ONES  = 3'h7;
	localparam logic [7:0] CFGA_VALUE = 8'h10;
	localparam logic [5:0] CFGB_ONES  = 6'h3F;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;
	// ------------------------------------------------------------
	// sizes and timing
	// ------------------------------------------------------------
	localparam int FIFO_DEPTH  = 16;
	localparam int SVC_THRESH  = 8;
	localparam int CLK_NS      = 100;
	localparam int STROBE_NS   = 500;
	localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	typedef struct packed {
		logic       cmd;
		logic [7:0] byte_v;
	} fifo_word_t;
endpackage : ppt_pkg

/* File: rtl/ppt_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ppt_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_b_i,
	input  wire logic                   flush_i,
	input  wire logic [WIDTH-1:0]       in_data_i,
	input  wire logic                   in_valid_i,
	output var  logic                   in_ready_o,
	output var  logic [WIDTH-1:0]       out_data_o,
	output var  logic                   out_valid_o,
	input  wire logic                   out_ready_i,
	output var  logic [$clog2(DEPTH):0] count_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      cnt_ff;
	logic             push;
	logic             pop;
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
			$error("fifo depth must be a power of two");
		end
	endgenerate
	assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o  = mem_ff[rd_ff];
	assign count_o     = cnt_ff;
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_ready_i && out_valid_o;
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || flush_i) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff  <= push ? wr_ff + 1'b1 : wr_ff;
			rd_ff  <= pop ? rd_ff + 1'b1 : rd_ff;
			cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule : ppt_fifo
`default_nettype wire

/* File: verif/ppt_port_asserts.sv */
// concurrent checks on the parallel port pins and register answers
`timescale 1ns/1ns
`default_nettype none
module ppt_port_chk
	import ppt_pkg::*;
(
	input wire logic        MCLK_I,
	input wire logic        RST_B_I,
	input wire logic [1:0]  BASE_SEL_I,
	input wire logic        EPP_OPTION_I,
	input wire logic [15:0] IO_ADDR_I,
	input wire logic        IO_WR_I,
	input wire logic        IO_RD_I,
	input wire logic [7:0]  IO_WDATA_I,
	input wire logic [7:0]  IO_RDATA_O,
	input wire logic        IO_RVALID_O,
	input wire logic        IRQ_O,
	input wire logic        PD_OE_O,
	input wire logic        STROBE_B_O,
	input wire logic        AUTOFD_B_O,
	input wire logic        INIT_B_O,
	input wire logic        SELIN_B_O,
	input wire logic        BUSY_I,
	input wire logic        ACK_B_I,
	input wire logic        PERROR_I,
	input wire logic        SELECT_I,
	input wire logic        FAULT_B_I
);
	logic [15:0] base;
	logic [15:0] off;
	logic [2:0]  mode_ff;
	logic        ack_ie_ff;
	logic        act;
	logic        rd;
	logic        wr;
	logic [3:0]  wd_lo;
	logic [3:0]  pins;
	logic [3:0]  stat_in;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_B_I);
	// ----
	// shadow of mode and ack enable, rebuilt from bus writes
	// ----
	assign base = (BASE_SEL_I == SEL_278) ? BASE_278 :
		(BASE_SEL_I == SEL_3BC) ? BASE_3BC : BASE_378;
	assign act = (BASE_SEL_I != 2'h3) &&
		!(BASE_SEL_I == SEL_3BC && EPP_OPTION_I && mode_ff == 3'h4);
	assign off = IO_ADDR_I - base;
	assign rd = act && IO_RD_I;
	assign wr = act && IO_WR_I;
	assign wd_lo = IO_WDATA_I[3:0];
	assign pins = {SELIN_B_O, INIT_B_O, AUTOFD_B_O, STROBE_B_O} ^ 4'hB;
	assign stat_in = {ACK_B_I, PERROR_I, SELECT_I, FAULT_B_I};
	// illegal mode writes leave the mode alone, so the shadow does too
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			mode_ff   <= 3'h0;
			ack_ie_ff <= 1'b0;
		end else begin
			if (wr && off == OFF_ECR && (mode_ff < 3'h2 || IO_WDATA_I[7:6] == 2'h0))
				mode_ff <= IO_WDATA_I[7:5];
			if (wr && off == OFF_CTRL)
				ack_ie_ff <= IO_WDATA_I[CTL_ACK_IE];
		end
	end
	sequence strobe_pulse;
		!STROBE_B_O [*5] ##1 STROBE_B_O;
	endsequence
	a_ctl_drives_pins: assert property (
		wr && off == OFF_CTRL && mode_ff == 3'h0 |-> ##2 pins == $past(wd_lo, 2))
		else $error("control bits not on pins");
	a_status_answer: assert property (
		rd && off == OFF_STATUS |=> IO_RVALID_O &&
		IO_RDATA_O == {!$past(BUSY_I), $past(stat_in), STAT_ONES})
		else $error("status read wrong");
	a_ctl_top_ones: assert property (
		rd && off == OFF_CTRL |=> IO_RVALID_O && IO_RDATA_O[7:6] == CTL_ONES)
		else $error("control top bits not ones");
	a_cfga_fixed: assert property (
		rd && off == OFF_FIFO && mode_ff == 3'h7 |=> IO_RDATA_O == CFGA_VALUE)
		else $error("config A value wrong");
	a_mode_field: assert property (
		rd && off == OFF_ECR |=> IO_RDATA_O[7:5] == $past(mode_ff))
		else $error("mode field wrong");
	a_out_driven: assert property (
		((mode_ff == 3'h0 || mode_ff == 3'h2) && BASE_SEL_I != 2'h3) [*3]
		|-> PD_OE_O)
		else $error("data lines not driven");
	a_compat_strobe: assert property (
		$fell(STROBE_B_O) && mode_ff == 3'h2 |-> strobe_pulse)
		else $error("strobe pulse length wrong");
	a_ack_raises_irq: assert property (
		$rose(ACK_B_I) && ack_ie_ff |=> IRQ_O)
		else $error("no ack interrupt");
endmodule : ppt_port_chk
bind ppt_port ppt_port_chk chk (.MCLK_I, .RST_B_I, .BASE_SEL_I, .EPP_OPTION_I,
	.IO_ADDR_I, .IO_WR_I, .IO_RD_I, .IO_WDATA_I, .IO_RDATA_O, .IO_RVALID_O,
	.IRQ_O, .PD_OE_O, .STROBE_B_O, .AUTOFD_B_O, .INIT_B_O, .SELIN_B_O,
	.BUSY_I, .ACK_B_I, .PERROR_I, .SELECT_I, .FAULT_B_I);
`default_nettype wire

/* File: verif/ppt_periph.sv */
// printer-like peripheral: takes a byte per strobe, answers with busy
`timescale 1ns/1ns
`default_nettype none
module ppt_periph (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       strobe_b_i,
	input  wire logic       autofd_b_i,
	input  wire logic [7:0] pd_i,
	input  wire logic       pd_oe_i,
	input  wire logic [7:0] rev_byte_i,
	input  wire logic       slow_i,
	output var  logic       busy_o,
	output var  logic [7:0] pd_o
);
	logic [7:0] got[$];
	logic       tag[$];
	int         hold;
	// host owns the lines while enabled, else the peripheral drives
	assign pd_o = pd_oe_i ? pd_i : rev_byte_i;
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			busy_o <= 1'b0;
			hold   <= 0;
		end else if (!strobe_b_i && !busy_o) begin
			got.push_back(pd_i);
			tag.push_back(autofd_b_i);
			busy_o <= 1'b1;
			hold   <= slow_i ? 12 : 1;
		end else if (busy_o && strobe_b_i) begin
			if (hold == 0)
				busy_o <= 1'b0;
			else
				hold <= hold - 1;
		end
	end
endmodule : ppt_periph
`default_nettype wire

/* File: verif/ppt_port_tb.sv */
// self-checking bench of the parallel port register block
`timescale 1ns/1ns
`default_nettype none
module ppt_port_tb
	import ppt_pkg::*;
;
	logic        MCLK_I = 1'b0, RST_B_I = 1'b0, EPP_OPTION_I = 1'b0;
	logic        IO_WR_I = 1'b0, IO_RD_I = 1'b0, slow = 1'b0;
	logic        DMA_ACK_I = 1'b0, DMA_TC_I = 1'b0, DMA_REQ_O;
	logic        ACK_B_I = 1'b1, PERROR_I = 1'b0, SELECT_I = 1'b0;
	logic        FAULT_B_I = 1'b1, IO_RVALID_O, IRQ_O, PD_OE_O, BUSY_I;
	logic        STROBE_B_O, AUTOFD_B_O, INIT_B_O, SELIN_B_O;
	logic [1:0]  BASE_SEL_I = SEL_378;
	logic [15:0] IO_ADDR_I = 16'h0000, base = BASE_378;
	logic [15:0] bases[3] = '{BASE_378, BASE_278, BASE_3BC};
	logic [7:0]  IO_WDATA_I = 8'h00, rev_byte = 8'h00;
	logic [7:0]  IO_RDATA_O, PD_I, PD_O, v;
	logic [7:0]  q[$];
	int          miscompares = 0, comparisons = 0, r, n, n0;
	ppt_port dut (.MCLK_I, .RST_B_I, .BASE_SEL_I, .EPP_OPTION_I, .IO_ADDR_I,
		.IO_WR_I, .IO_RD_I, .IO_WDATA_I, .IO_RDATA_O, .IO_RVALID_O, .DMA_REQ_O,
		.DMA_ACK_I, .DMA_TC_I, .IRQ_O, .PD_I, .PD_O, .PD_OE_O,
		.STROBE_B_O, .AUTOFD_B_O, .INIT_B_O, .SELIN_B_O, .BUSY_I, .ACK_B_I,
		.PERROR_I, .SELECT_I, .FAULT_B_I);
	ppt_periph per (.clk_i(MCLK_I), .rst_b_i(RST_B_I), .strobe_b_i(STROBE_B_O),
		.autofd_b_i(AUTOFD_B_O),
		.pd_i(PD_O), .pd_oe_i(PD_OE_O), .rev_byte_i(rev_byte), .slow_i(slow),
		.busy_o(BUSY_I), .pd_o(PD_I));
	initial forever #50 MCLK_I = ~MCLK_I;
	// ----
	// bus cycles and comparison
	// ----
	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// bounded wait for the peripheral to have taken k bytes
	task automatic wait_got(input int k);
		n = 0;
		while (per.got.size() < k && n < 800) begin
			@(posedge MCLK_I);
			n++;
		end
		if (n == 800) begin
			miscompares++;
			report_and_stop();
		end
	endtask : wait_got
	task automatic wr(input logic [15:0] off, input logic [7:0] d);
		@(posedge MCLK_I);
		IO_ADDR_I  <= base + off;
		IO_WDATA_I <= d;
		IO_WR_I    <= 1'b1;
		@(posedge MCLK_I);
		IO_WR_I    <= 1'b0;
	endtask : wr
	// answer comes exactly one cycle after the read, so no polling
	task automatic rd(input logic [15:0] off, input bit want, output logic [7:0] d);
		@(posedge MCLK_I);
		IO_ADDR_I <= base + off;
		IO_RD_I   <= 1'b1;
		@(posedge MCLK_I);
		IO_RD_I   <= 1'b0;
		#1;
		if (!want)
			chk(IO_RVALID_O, 1'b0);
		else
			chk(IO_RVALID_O, 1'b1);
		d = IO_RDATA_O;
	endtask : rd
	initial begin
		r = $urandom(58623);
		repeat (5) @(posedge MCLK_I);
		RST_B_I <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			BASE_SEL_I <= 2'(i);
			base = bases[i];
			rd(OFF_CTRL, 1'b1, v); chk(v, 8'hC0);
		end
		BASE_SEL_I <= 2'h3;
		rd(OFF_CTRL, 1'b0, v);
		BASE_SEL_I <= SEL_378;
		base = BASE_378;
		rd(16'h0003, 1'b0, v);
		rd(OFF_ECR, 1'b1, v); chk(v, 8'h15);
		repeat (4) begin
			r = $urandom();
			{ACK_B_I, PERROR_I, SELECT_I, FAULT_B_I} <= r[3:0];
			rd(OFF_STATUS, 1'b1, v); chk(v, {1'b1, r[3:0], 3'h7});
		end
		repeat (4) begin
			r = $urandom();
			wr(OFF_CTRL, r[7:0]);
			rd(OFF_CTRL, 1'b1, v); chk(v, {3'h6, r[4:0]});
			chk({SELIN_B_O, INIT_B_O, AUTOFD_B_O, STROBE_B_O}, r[3:0] ^ 4'hB);
		end
		wr(OFF_CTRL, 8'h10);
		ACK_B_I <= 1'b0;
		@(posedge MCLK_I);
		ACK_B_I <= 1'b1;
		@(posedge MCLK_I);
		#1 chk(IRQ_O, 1'b1);
		wr(OFF_ECR, 8'hF4);
		rd(OFF_FIFO, 1'b1, v); chk(v, CFGA_VALUE);
		rd(OFF_CFGB, 1'b1, v); chk(v, 8'h3F);
		wr(OFF_ECR, 8'h54);
		rd(OFF_ECR, 1'b1, v); chk(v[7:5], 3'h7);
		wr(OFF_ECR, 8'h14);
		BASE_SEL_I <= SEL_3BC;
		base = BASE_3BC;
		EPP_OPTION_I <= 1'b1;
		wr(OFF_ECR, 8'h94);
		rd(OFF_CTRL, 1'b0, v);
		BASE_SEL_I <= SEL_378;
		base = BASE_378;
		rd(OFF_ECR, 1'b1, v); chk(v, 8'h95);
		// leaving 100 must pass through 000 or 001 first
		wr(OFF_ECR, 8'h14);
		wr(OFF_ECR, 8'hD4);
		n0 = per.got.size();
		for (int i = 0; i < 17; i++) begin
			r = $urandom();
			wr(OFF_FIFO, r[7:0]);
			if (i < FIFO_DEPTH)
				q.push_back(r[7:0]);
		end
		rd(OFF_ECR, 1'b1, v); chk(v, 8'hD6);
		foreach (q[i]) begin
			rd(OFF_FIFO, 1'b1, v); chk(v, q[i]);
		end
		rd(OFF_ECR, 1'b1, v); chk(v, 8'hD5);
		chk(8'(per.got.size() - n0), 8'h00);
		// dma byte with terminal count, then the free-space threshold
		wr(OFF_ECR, 8'hD8);
		@(posedge MCLK_I);
		#1 chk(DMA_REQ_O, 1'b1);
		r = $urandom();
		@(posedge MCLK_I);
		IO_WDATA_I <= r[7:0];
		DMA_ACK_I  <= 1'b1;
		DMA_TC_I   <= 1'b1;
		@(posedge MCLK_I);
		DMA_ACK_I  <= 1'b0;
		DMA_TC_I   <= 1'b0;
		#1 chk(IRQ_O, 1'b1);
		rd(OFF_ECR, 1'b1, v); chk(v, 8'hDC);
		chk(DMA_REQ_O, 1'b0);
		rd(OFF_FIFO, 1'b1, v); chk(v, r[7:0]);
		wr(OFF_ECR, 8'hD0);
		@(posedge MCLK_I);
		#1 chk(IRQ_O, 1'b1);
		rd(OFF_ECR, 1'b1, v); chk(v, 8'hD5);
		wr(OFF_FIFO, 8'hA5);
		wr(OFF_ECR, 8'h14);
		rd(OFF_ECR, 1'b1, v); chk(v, 8'h15);
		// compatibility fifo: each byte waits for the peripheral's busy
		wr(OFF_ECR, 8'h54);
		q.delete();
		per.got.delete();
		repeat (5) begin
			r = $urandom();
			slow <= r[8];
			wr(OFF_FIFO, r[7:0]);
			q.push_back(r[7:0]);
		end
		wait_got(5);
		foreach (q[i]) chk(per.got[i], q[i]);
		repeat (30) @(posedge MCLK_I);
		// ecp forward: command byte then data byte through one fifo
		wr(OFF_ECR, 8'h14);
		wr(OFF_ECR, 8'h74);
		per.got.delete();
		per.tag.delete();
		r = $urandom();
		wr(OFF_DATA, r[7:0]);
		wr(OFF_FIFO, r[15:8]);
		wait_got(2);
		chk(per.got[0], r[7:0]);
		chk(per.got[1], r[15:8]);
		chk(per.tag[0], 1'b0);
		chk(per.tag[1], 1'b1);
		wr(OFF_ECR, 8'h34);
		wr(OFF_CTRL, 8'h20);
		rev_byte <= 8'(~$urandom());
		rd(OFF_DATA, 1'b1, v); chk(v, rev_byte);
		chk(PD_OE_O, 1'b0);
		wr(OFF_CTRL, 8'h00);
		wr(OFF_ECR, 8'h14);
		repeat (5) @(posedge MCLK_I);
		report_and_stop();
	end
endmodule : ppt_port_tb
`default_nettype wire
